/* hdl/gcd_pkg.sv */
// Constants, register map and types for the graphics command dispatcher.
// Assumes a 32-bit AHB-Lite register bus and external queues and pixel engine.
package gcd_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_THRESH = 8'h08;
  localparam logic [7:0] OFS_RECT_MIN = 8'h0c;
  localparam logic [7:0] OFS_RECT_MAX = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_TRANS_COL = 8'h18;
  localparam logic [7:0] OFS_LINE_COL = 8'h1c;
  localparam logic [7:0] OFS_FLAG_CLR = 8'h20;

  // ----------------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------------
  localparam int FB_INQ_FULL = 0;
  localparam int FB_INQ_EMPTY = 1;
  localparam int FB_INQ_HIGH = 2;
  localparam int FB_INQ_LOW = 3;
  localparam int FB_OUTQ_FULL = 4;
  localparam int FB_OUTQ_EMPTY = 5;
  localparam int FB_OUTQ_HIGH = 6;
  localparam int FB_OUTQ_LOW = 7;
  localparam int FB_ENGINE_BUSY = 8;
  localparam int FB_BAD_CODE = 16;
  localparam int FB_OVERFLOW = 17;
  localparam int FB_CMD_WEN = 22;

  // ----------------------------------------------------------------------
  // Queues
  // ----------------------------------------------------------------------
  localparam int LVL_W = 6;
  localparam logic [LVL_W-1:0] QUEUE_DEPTH = 6'h20;
  localparam logic [LVL_W-1:0] THR_LOW_RST = 6'h04;
  localparam logic [LVL_W-1:0] THR_HIGH_RST = 6'h1c;

  // ----------------------------------------------------------------------
  // Command codes and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] CODE_SOFT_RESET = 8'h00;
  localparam logic [7:0] CODE_RAW_BITMAP = 8'h01;
  localparam logic [7:0] CODE_RLE_BITMAP = 8'h02;
  localparam logic [7:0] CODE_DRAW_LINE = 8'h03;
  localparam int CODE_LANE = 0;

  typedef struct packed {
    logic [15:0] min_x;
    logic [15:0] min_y;
    logic [15:0] max_x;
    logic [15:0] max_y;
    logic [3:0] command_layer;
    logic use_command_layer;
    logic command_enable;
    logic [1:0] draw_direction;
    logic [1:0] draw_mirror;
    logic transparent_colour_enable;
    logic [23:0] transparent_colour_value;
    logic [23:0] line_colour;
    logic [2:0] depth;
    logic [31:0] word_count;
  } gcd_params_t;

endpackage : gcd_pkg

/* hdl/gcd_dispatch.sv */
// Command front end of the graphics controller: AHB-Lite register slave,
// status flags and command dispatch to the pixel engine.
// Assumes external input/output queues reporting fill levels and a pixel
// engine that holds engine_busy while it executes a command.
//
// Overview of operation
// - Status bit 8 is high while the pixel engine executes a command.
// - Status bit 7 set while output queue level at or below lower threshold.
// - Status bit 6 set while output queue level at or above upper threshold.
// - Status bit 5 set while output queue is empty.
// - Status bit 4 set while output queue is full.
// - Status bit 3 set while input queue level at or below lower threshold.
// - Status bit 2 set while input queue level at or above upper threshold.
// - Status bit 1 set while input queue is empty.
// - Status bit 0 set while input queue is full.
// - Command word is 32 bits: code in bits 7:0, parameters in 31:8.
// - Partial command writes update only the written bytes.
// - Writing the code byte starts the command; parameters must come first or together.
// - Parameter bits are ignored by commands that take none.
// - Parameter registers are double buffered and apply at next command start.
// - Code 00h resets command units and clears all queues.
// - Code 01h stores an uncompressed bitmap; word count area*bpp/32.
// - Bitmap stores use rectangle, layer and mirroring settings.
// - Code 02h stores a run-length compressed bitmap.
// - Code 03h draws lines endlessly in the line colour from queue points.
// - With use-command-layer set, line endpoints take the command layer.
// - Bit 22 shows when a command may be written.
// - Writing a command while bit 22 is low sets overflow bit 17.
// - Undefined code sets bad-code bit 16 and acts as no-operation.
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
module gcd_dispatch (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [gcd_pkg::LVL_W-1:0] inq_level,
  input wire logic [gcd_pkg::LVL_W-1:0] outq_level,
  input wire logic engine_busy,
  output logic engine_start,
  output logic [7:0] engine_code,
  output gcd_pkg::gcd_params_t engine_params,
  output logic unit_reset,
  output logic queue_clear
);
  import gcd_pkg::*;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Colour depth codes: 0..5 select 1, 2, 4, 8, 16, 24 bits per pixel
  function automatic logic [5:0] gcd_bpp(input logic [2:0] depth);
    unique case (depth)
      3'h0: gcd_bpp = 6'h01;
      3'h1: gcd_bpp = 6'h02;
      3'h2: gcd_bpp = 6'h04;
      3'h3: gcd_bpp = 6'h08;
      3'h4: gcd_bpp = 6'h10;
      default: gcd_bpp = 6'h18;
    endcase
  endfunction : gcd_bpp

  // Keeps only the colour bits that the depth uses
  function automatic logic [23:0] gcd_col_mask(input logic [2:0] depth);
    gcd_col_mask = (24'h000001 << gcd_bpp(depth)) - 24'h000001;
    if (depth > 3'h4) begin
      gcd_col_mask = 24'hffffff;
    end
  endfunction : gcd_col_mask

  // AHB byte lanes from hsize and the low address bits
  function automatic logic [3:0] gcd_lanes(input logic [2:0] size, input logic [1:0] a);
    unique case (size)
      3'h0: gcd_lanes = 4'h1 << a;
      3'h1: gcd_lanes = a[1] ? 4'hc : 4'h3;
      default: gcd_lanes = 4'hf;
    endcase
  endfunction : gcd_lanes

  // Byte-lane merge of write data into a stored word
  function automatic logic [31:0] gcd_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      gcd_merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : gcd_merge

  // ----------------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------------
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [3:0] wr_be_r, wr_be_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic addr_taken;
  logic addr_mapped;

  // ----------------------------------------------------------------------
  // Host-visible shadow registers
  // ----------------------------------------------------------------------
  logic [31:0] command_word_r, command_word_nxt;
  logic [31:0] thresh_r, thresh_nxt;
  logic [31:0] rect_min_r, rect_min_nxt;
  logic [31:0] rect_max_r, rect_max_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [23:0] trans_col_r, trans_col_nxt;
  logic [23:0] line_col_r, line_col_nxt;

  // ----------------------------------------------------------------------
  // Dispatch and status state
  // ----------------------------------------------------------------------
  logic [31:0] status_r, status_nxt;
  logic pending_r, pending_nxt;
  logic overflow_r, overflow_nxt;
  logic bad_code_r, bad_code_nxt;
  logic start_r, start_nxt;
  logic [7:0] code_r, code_nxt;
  gcd_params_t params_r, params_nxt;
  logic unit_reset_r, unit_reset_nxt;
  logic queue_clear_r, queue_clear_nxt;

  logic cmd_wen;
  logic cmd_write;
  logic flag_reset;
  logic [31:0] wdata_merged;
  logic [7:0] new_code;
  logic [15:0] span_x, span_y;
  logic [47:0] area_bits;

  assign addr_taken = hsel & hready & htrans[1];
  assign addr_mapped = haddr[31:8] == 24'h000000;
  assign cmd_wen = ~engine_busy & ~pending_r;
  assign wdata_merged = gcd_merge(command_word_r, hwdata, wr_be_r);
  assign new_code = wdata_merged[7:0];
  assign cmd_write = wr_pend_r & (wr_addr_r == OFS_COMMAND) & wr_be_r[CODE_LANE];
  assign flag_reset = wr_pend_r & (wr_addr_r == OFS_FLAG_CLR);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  always_comb begin
    wr_pend_nxt = addr_taken & hwrite & addr_mapped;
    wr_addr_nxt = wr_addr_r;
    wr_be_nxt = wr_be_r;
    hrdata_nxt = hrdata_r;
    if (addr_taken) begin
      wr_addr_nxt = {haddr[7:2], 2'b00};
      wr_be_nxt = gcd_lanes(hsize, haddr[1:0]);
    end
    if (addr_taken & ~hwrite) begin
      if (!addr_mapped) begin
        hrdata_nxt = 32'h00000000;
      end else begin
        unique case ({haddr[7:2], 2'b00})
          OFS_STATUS: hrdata_nxt = status_r;
          OFS_THRESH: hrdata_nxt = thresh_r;
          OFS_RECT_MIN: hrdata_nxt = rect_min_r;
          OFS_RECT_MAX: hrdata_nxt = rect_max_r;
          OFS_CTRL: hrdata_nxt = ctrl_r;
          OFS_TRANS_COL: hrdata_nxt = {8'h00, trans_col_r};
          OFS_LINE_COL: hrdata_nxt = {8'h00, line_col_r};
          default: hrdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_be_r <= 4'h0;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_be_r <= wr_be_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Shadow register writes
  // ----------------------------------------------------------------------
  always_comb begin
    command_word_nxt = command_word_r;
    thresh_nxt = thresh_r;
    rect_min_nxt = rect_min_r;
    rect_max_nxt = rect_max_r;
    ctrl_nxt = ctrl_r;
    trans_col_nxt = trans_col_r;
    line_col_nxt = line_col_r;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        OFS_COMMAND: command_word_nxt = wdata_merged;
        OFS_THRESH: thresh_nxt = gcd_merge(thresh_r, hwdata, wr_be_r);
        OFS_RECT_MIN: rect_min_nxt = gcd_merge(rect_min_r, hwdata, wr_be_r);
        OFS_RECT_MAX: rect_max_nxt = gcd_merge(rect_max_r, hwdata, wr_be_r);
        OFS_CTRL: ctrl_nxt = gcd_merge(ctrl_r, hwdata, wr_be_r);
        OFS_TRANS_COL: trans_col_nxt = 24'(gcd_merge({8'h00, trans_col_r}, hwdata, wr_be_r));
        OFS_LINE_COL: line_col_nxt = 24'(gcd_merge({8'h00, line_col_r}, hwdata, wr_be_r));
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      command_word_r <= 32'h00000000;
      thresh_r <= {2'b00, THR_HIGH_RST, 2'b00, THR_LOW_RST, 2'b00, THR_HIGH_RST, 2'b00,
                   THR_LOW_RST};
      rect_min_r <= 32'h00000000;
      rect_max_r <= 32'h00000000;
      ctrl_r <= 32'h00000000;
      trans_col_r <= 24'h000000;
      line_col_r <= 24'h000000;
    end else begin
      command_word_r <= command_word_nxt;
      thresh_r <= thresh_nxt;
      rect_min_r <= rect_min_nxt;
      rect_max_r <= rect_max_nxt;
      ctrl_r <= ctrl_nxt;
      trans_col_r <= trans_col_nxt;
      line_col_r <= line_col_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Command dispatch
  // ----------------------------------------------------------------------
  assign span_x = rect_max_r[15:0] - rect_min_r[15:0] + 16'h0001;
  assign span_y = rect_max_r[31:16] - rect_min_r[31:16] + 16'h0001;
  assign area_bits = 48'(span_x) * 48'(span_y) * 48'(gcd_bpp(ctrl_r[14:12]));

  always_comb begin
    // Busy holds from start until the engine raises its own flag
    pending_nxt = pending_r & ~engine_busy;
    overflow_nxt = overflow_r;
    bad_code_nxt = bad_code_r;
    start_nxt = 1'b0;
    code_nxt = code_r;
    params_nxt = params_r;
    unit_reset_nxt = 1'b0;
    queue_clear_nxt = 1'b0;
    if (flag_reset) begin
      overflow_nxt = 1'b0;
      bad_code_nxt = 1'b0;
    end
    if (cmd_write & ~cmd_wen) begin
      overflow_nxt = 1'b1;
    end else if (cmd_write) begin
      unique case (new_code)
        CODE_SOFT_RESET: begin
          unit_reset_nxt = 1'b1;
          queue_clear_nxt = 1'b1;
          pending_nxt = 1'b0;
        end
        CODE_RAW_BITMAP, CODE_RLE_BITMAP, CODE_DRAW_LINE: begin
          start_nxt = 1'b1;
          pending_nxt = 1'b1;
          code_nxt = new_code;
          // Shadow values become active only here
          params_nxt.min_x = rect_min_r[15:0];
          params_nxt.min_y = rect_min_r[31:16];
          params_nxt.max_x = rect_max_r[15:0];
          params_nxt.max_y = rect_max_r[31:16];
          params_nxt.command_layer = ctrl_r[3:0];
          params_nxt.use_command_layer = ctrl_r[4];
          params_nxt.command_enable = ctrl_r[5];
          params_nxt.draw_direction = ctrl_r[7:6];
          params_nxt.draw_mirror = ctrl_r[9:8];
          params_nxt.transparent_colour_enable = ctrl_r[10];
          params_nxt.transparent_colour_value = trans_col_r;
          params_nxt.line_colour = line_col_r & gcd_col_mask(ctrl_r[14:12]);
          params_nxt.depth = ctrl_r[14:12];
          params_nxt.word_count = 32'(area_bits >> 5);
        end
        default: bad_code_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending_r <= 1'b0;
      overflow_r <= 1'b0;
      bad_code_r <= 1'b0;
      start_r <= 1'b0;
      code_r <= 8'h00;
      params_r <= '0;
      unit_reset_r <= 1'b0;
      queue_clear_r <= 1'b0;
    end else begin
      pending_r <= pending_nxt;
      overflow_r <= overflow_nxt;
      bad_code_r <= bad_code_nxt;
      start_r <= start_nxt;
      code_r <= code_nxt;
      params_r <= params_nxt;
      unit_reset_r <= unit_reset_nxt;
      queue_clear_r <= queue_clear_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  always_comb begin
    status_nxt = 32'h00000000;
    status_nxt[FB_INQ_FULL] = inq_level == QUEUE_DEPTH;
    status_nxt[FB_INQ_EMPTY] = inq_level == '0;
    status_nxt[FB_INQ_HIGH] = inq_level >= thresh_r[13:8];
    status_nxt[FB_INQ_LOW] = inq_level <= thresh_r[5:0];
    status_nxt[FB_OUTQ_FULL] = outq_level == QUEUE_DEPTH;
    status_nxt[FB_OUTQ_EMPTY] = outq_level == '0;
    status_nxt[FB_OUTQ_HIGH] = outq_level >= thresh_r[29:24];
    status_nxt[FB_OUTQ_LOW] = outq_level <= thresh_r[21:16];
    status_nxt[FB_ENGINE_BUSY] = engine_busy | pending_r;
    // Flag clear zeroes level and busy bits for one update
    if (flag_reset) begin
      status_nxt[FB_ENGINE_BUSY:0] = '0;
    end
    status_nxt[FB_BAD_CODE] = bad_code_nxt;
    status_nxt[FB_OVERFLOW] = overflow_nxt;
    status_nxt[FB_CMD_WEN] = cmd_wen & ~start_nxt;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= 32'h00000000;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic hready_r, hresp_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  assign hreadyout = hready_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign engine_start = start_r;
  assign engine_code = code_r;
  assign engine_params = params_r;
  assign unit_reset = unit_reset_r;
  assign queue_clear = queue_clear_r;

endmodule : gcd_dispatch

/* dv/gcd_engine_model.sv */
// Behavioural pixel engine that answers command starts from the dispatcher.
// Assumes one clock and the dispatcher's active-high asynchronous reset.
module gcd_engine_model #(
  parameter int BUSY_LEN = 30
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic engine_start,
  input wire logic unit_reset,
  output logic engine_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // ------------------------------------------------------------------
  // Busy from each start until a BUSY_LEN-cycle count runs out, or until unit reset
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst || unit_reset) begin
      cnt <= 0;
      engine_busy <= 1'b0;
    end else if (engine_start) begin
      cnt <= BUSY_LEN;
      engine_busy <= 1'b1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      engine_busy <= 1'b0;
    end
  end
endmodule : gcd_engine_model

/* dv/gcd_dispatch_monitor.sv */
// Port checker for the command dispatcher, bound into gcd_dispatch.
// Assumes one AHB-Lite master with hready tied to hreadyout.
module gcd_dispatch_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [gcd_pkg::LVL_W-1:0] inq_level,
  input wire logic [gcd_pkg::LVL_W-1:0] outq_level,
  input wire logic engine_busy,
  input wire logic engine_start,
  input wire logic [7:0] engine_code,
  input wire gcd_pkg::gcd_params_t engine_params,
  input wire logic unit_reset,
  input wire logic queue_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  import gcd_pkg::*;
  logic take, steady, cmd_r, rd_r, eb1_r, eb2_r;
  logic [2:0] clr_r, up_r;
  logic [5:0] iq1_r, iq2_r, oq1_r, oq2_r;
  // ------------------------------------------------------------------
  // Helper history of bus requests and inputs
  // ------------------------------------------------------------------
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {cmd_r, rd_r, eb1_r, eb2_r, clr_r, up_r} <= '0;
      {iq1_r, iq2_r, oq1_r, oq2_r} <= '0;
    end else begin
      cmd_r <= take && hwrite && haddr == {24'h0, OFS_COMMAND};
      rd_r <= take && !hwrite && haddr == {24'h0, OFS_STATUS};
      clr_r <= {clr_r[1:0], take && hwrite && haddr == {24'h0, OFS_FLAG_CLR}};
      up_r <= {up_r[1:0], 1'b1};
      {iq2_r, iq1_r, oq2_r, oq1_r} <= {iq1_r, inq_level, oq1_r, outq_level};
      {eb2_r, eb1_r} <= {eb1_r, engine_busy};
    end
  end
  // Inputs unchanged over the status lag, no flag clear in flight
  assign steady = &up_r && clr_r == 3'h0 && inq_level == iq1_r && iq1_r == iq2_r &&
    outq_level == oq1_r && oq1_r == oq2_r && engine_busy == eb1_r && eb1_r == eb2_r;
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  start_cause_a: assert property (engine_start |-> $past(cmd_r) &&
    $past(hwdata[7:0]) inside {8'h01, 8'h02, 8'h03} && engine_code == $past(hwdata[7:0]))
    else $error("engine start without a valid command write");
  reset_pulse_a: assert property (unit_reset |-> queue_clear && !engine_start &&
    $past(cmd_r) && $past(hwdata[7:0]) == CODE_SOFT_RESET)
    else $error("unit reset without a soft reset command");
  busy_refuse_a: assert property (engine_start |-> !$past(engine_busy))
    else $error("command started while engine busy");
  start_gap_a: assert property (engine_start |=> !engine_start [*3])
    else $error("engine starts too close together");
  code_hold_a: assert property (!engine_start |-> $stable(engine_code))
    else $error("engine code changed without a start");
  params_hold_a: assert property (!engine_start |-> $stable(engine_params))
    else $error("engine parameters changed without a start");
  inq_flags_a: assert property (rd_r && steady |-> hrdata[FB_INQ_EMPTY] ==
    (inq_level == 6'h00) && hrdata[FB_INQ_FULL] == (inq_level == QUEUE_DEPTH))
    else $error("input queue empty or full flag wrong");
  outq_flags_a: assert property (rd_r && steady |-> hrdata[FB_OUTQ_EMPTY] ==
    (outq_level == 6'h00) && hrdata[FB_OUTQ_FULL] == (outq_level == QUEUE_DEPTH))
    else $error("output queue empty or full flag wrong");
  busy_flag_a: assert property (rd_r && steady && engine_busy |->
    hrdata[FB_ENGINE_BUSY] && !hrdata[FB_CMD_WEN])
    else $error("busy flag wrong while engine runs");
  start_cov: cover property (engine_start);
  reset_cov: cover property (unit_reset);
  busy_cov: cover property (rd_r && steady && engine_busy);
endmodule : gcd_dispatch_monitor

bind gcd_dispatch gcd_dispatch_monitor gcd_dispatch_monitor_i (.clk, .sys_rst, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .inq_level,
  .outq_level, .engine_busy, .engine_start, .engine_code, .engine_params, .unit_reset,
  .queue_clear);

/* dv/gcd_dispatch_tb.sv */
// Self-checking bench for the command dispatcher with an engine model.
// Assumes the bench is the only AHB-Lite master and drives the queue levels.
module gcd_dispatch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gcd_pkg::*;
  logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0;
  logic hreadyout, hresp, engine_busy, engine_start, unit_reset, queue_clear;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [LVL_W-1:0] inq_level = 0, outq_level = 0;
  logic [7:0] engine_code;
  gcd_params_t engine_params;
  int fail_count = 0, n_checks = 0, n_start = 0, n_rst = 0;
  logic [5:0] il = THR_LOW_RST, ih = THR_HIGH_RST, ol = THR_LOW_RST, oh = THR_HIGH_RST;
  logic [5:0] tiq [7] = '{6'd0, 6'd4, 6'd5, 6'd32, 6'd10, 6'd20, 6'd11};
  logic [5:0] toq [7] = '{6'd32, 6'd28, 6'd27, 6'd0, 6'd2, 6'd30, 6'd29};

  gcd_dispatch gcd_dispatch_i (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .inq_level, .outq_level,
    .engine_busy, .engine_start, .engine_code, .engine_params, .unit_reset, .queue_clear);
  gcd_engine_model gcd_engine_model_i (.clk, .sys_rst, .engine_start, .unit_reset,
    .engine_busy);

  always #5 clk = ~clk;
  always @(negedge clk) begin
    n_start += (engine_start === 1'b1);
    n_rst += (unit_reset === 1'b1 && queue_clear === 1'b1);
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] sz,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdv = hrdata;
    hwdata <= ~d;
  endtask : bus

  task automatic rd_st(input string nm, input logic [31:0] mask, input logic [31:0] exp);
    repeat (3) @(posedge clk);
    bus(1'b0, OFS_STATUS, 3'h2, 32'h0);
    chk(nm, rdv & mask, exp);
  endtask : rd_st

  task automatic idle_wait;
    repeat (3) @(posedge clk);
    while (engine_busy !== 1'b0) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : idle_wait

  function automatic logic [31:0] flags(input logic [5:0] iq, input logic [5:0] oq);
    flags = 32'h0040_0000;
    flags[FB_INQ_FULL] = iq == QUEUE_DEPTH;
    flags[FB_INQ_EMPTY] = iq == 6'h00;
    flags[FB_INQ_HIGH] = iq >= ih;
    flags[FB_INQ_LOW] = iq <= il;
    flags[FB_OUTQ_FULL] = oq == QUEUE_DEPTH;
    flags[FB_OUTQ_EMPTY] = oq == 6'h00;
    flags[FB_OUTQ_HIGH] = oq >= oh;
    flags[FB_OUTQ_LOW] = oq <= ol;
  endfunction : flags
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    #100us;
    fail_count++;
    tally_and_finish;
  end

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      if (i == 4) begin
        bus(1'b1, OFS_THRESH, 3'h2, 32'h1e02_140a);
        {il, ih, ol, oh} = {6'd10, 6'd20, 6'd2, 6'd30};
      end
      inq_level <= tiq[i];
      outq_level <= toq[i];
      rd_st("levels", 32'hffff_ffff, flags(tiq[i], toq[i]));
    end
    bus(1'b1, OFS_RECT_MIN, 3'h2, 32'h0);
    bus(1'b1, OFS_RECT_MAX, 3'h2, 32'h0003_0007);
    bus(1'b1, OFS_CTRL, 3'h2, 32'h3605);
    bus(1'b1, OFS_TRANS_COL, 3'h2, 32'h0012_3456);
    bus(1'b1, OFS_LINE_COL, 3'h2, 32'h00ff_ffff);
    bus(1'b1, OFS_COMMAND, 3'h2, 32'habcd_ef01);
    rd_st("busy", 32'h0040_0100, 32'h0000_0100);
    chk("starts", n_start, 1);
    chk("code", engine_code, CODE_RAW_BITMAP);
    chk("words", engine_params.word_count, 32'h8);
    chk("rect", {engine_params.max_y, engine_params.max_x}, 32'h0003_0007);
    chk("mode", {engine_params.transparent_colour_enable, engine_params.draw_mirror,
      engine_params.command_layer}, 32'h65);
    chk("transp", engine_params.transparent_colour_value, 32'h0012_3456);
    chk("line", engine_params.line_colour, 32'hff);
    bus(1'b1, OFS_RECT_MAX, 3'h2, 32'h0009_0009);
    bus(1'b1, OFS_COMMAND, 3'h2, 32'h2);
    rd_st("overflow", 32'h0002_0000, 32'h0002_0000);
    chk("held", engine_params.max_x, 32'h7);
    chk("starts", n_start, 1);
    idle_wait;
    rd_st("idle", 32'h0040_0100, 32'h0040_0000);
    bus(1'b1, OFS_COMMAND, 3'h2, 32'h5);
    rd_st("bad code", 32'h0001_0000, 32'h0001_0000);
    chk("starts", n_start, 1);
    inq_level <= 6'd0;
    bus(1'b1, OFS_FLAG_CLR, 3'h2, 32'h0);
    bus(1'b0, OFS_STATUS, 3'h2, 32'h0);
    chk("flag reset", rdv & 32'h0003_01ff, 32'h0);
    rd_st("cleared", 32'h0003_01ff, flags(6'd0, toq[6]) & 32'h0000_01ff);
    bus(1'b1, OFS_CTRL, 3'h2, 32'h4010);
    bus(1'b1, OFS_LINE_COL, 3'h2, 32'h0012_abcd);
    bus(1'b1, 32'h5, 3'h0, 32'h0000_ff00);
    bus(1'b1, 32'h6, 3'h1, 32'hffff_0000);
    @(posedge clk);
    chk("starts", n_start, 1);
    bus(1'b1, OFS_COMMAND, 3'h0, 32'h3);
    @(posedge clk);
    chk("starts", n_start, 2);
    chk("code", engine_code, CODE_DRAW_LINE);
    chk("layer", engine_params.use_command_layer, 32'h1);
    chk("line", engine_params.line_colour, 32'habcd);
    chk("new max", engine_params.max_x, 32'h9);
    idle_wait;
    bus(1'b1, OFS_COMMAND, 3'h2, 32'h2);
    @(posedge clk);
    chk("code", engine_code, CODE_RLE_BITMAP);
    idle_wait;
    bus(1'b1, OFS_COMMAND, 3'h2, 32'h7777_7700);
    @(posedge clk);
    chk("resets", n_rst, 1);
    chk("starts", n_start, 3);
    bus(1'b0, 32'h40, 3'h2, 32'h0);
    chk("unmapped", rdv, 32'h0);
    bus(1'b0, OFS_COMMAND, 3'h2, 32'h0);
    chk("write only", rdv, 32'h0);
    tally_and_finish;
  end
endmodule : gcd_dispatch_tb
